// >>> hdl/flow_ctrl_pkg.sv
/*
   Types for the host serial flow-control block.
   Assumes flow_ctrl_regs.svh supplies the numeric constants.
*/
package flow_ctrl_pkg;

   // attention parser, gray along idle -> lead -> tens
   typedef enum logic [1:0] {
      ATTN_IDLE = 2'b00,
      ATTN_LEAD = 2'b01,
      ATTN_TENS = 2'b11
   } attn_t;

   typedef struct packed {
      attn_t       attn;
      logic [3:0]  tens;
      logic        paused;
      logic        xoff_sent;
      logic        pend_xon;
      logic        pend_xoff;
      logic [1:0]  late_cnt;
      logic        selected;
      logic        overrun;
      logic        tx_valid;
      logic [7:0]  tx_data;
   } flow_state_t;

endpackage : flow_ctrl_pkg

// >>> hdl/flow_ctrl_regs.svh
/*
   Constants for the host serial flow-control block: character codes,
   buffer-space thresholds and serial buffer sizing.
   Assumes 8-bit characters delivered by an external receiver.
*/
`ifndef FLOW_CTRL_REGS_SVH
`define FLOW_CTRL_REGS_SVH

// ****************************************
// character codes
// ****************************************
`define CHAR_XON        8'h11
`define CHAR_XOFF       8'h13
`define CHAR_CR         8'h0D
`define CHAR_ATTN       8'h3C
`define CHAR_DIGIT_LO   8'h30
`define CHAR_DIGIT_HI   8'h39

// ****************************************
// buffer space thresholds and sizing
// ****************************************
`define XOFF_FREE_MIN   8'h52
`define XON_FREE_LEVEL  8'h64
`define LATE_CHARS      2'h3
`define SERIAL_DEPTH    40
`define BROADCAST_UNIT  7'h00
`define TENS_WEIGHT     7'h0A

`endif

// >>> hdl/host_flow_ctrl.sv
/*
   Software flow control for the host serial port: pauses the host by
   sending stop/resume characters as command buffer space changes, and
   pauses its own output on the host's stop/resume characters.
   Assumes a receiver and transmitter outside, 8-bit characters, and a
   command buffer that reports its free positions.
*/
`timescale 1ns/1ps
`include "flow_ctrl_regs.svh"

// Notes on behaviour
// - on CR, send XOFF if free below 82
// - after XOFF, send XON at 100 free
// - answer matching attention with XON if space
// - keep three late characters, forty-character buffer
// - host XOFF stops our data transmission; XON/XOFF are still sent
// - host XON restarts our transmission
// - unit 00 addresses every controller
module host_flow_ctrl #(
   parameter int DEPTH = `SERIAL_DEPTH
) (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst,
   // received characters from host
   input  wire logic        rx_valid,
   input  wire logic [7:0]  rx_data,
   // characters to host
   output      logic        tx_valid,
   output      logic [7:0]  tx_data,
   input  wire logic        tx_ready,
   // outgoing controller data
   input  wire logic        app_valid,
   input  wire logic [7:0]  app_data,
   output      logic        app_ready,
   // stored characters toward the command parser
   output      logic        cmd_valid,
   output      logic [7:0]  cmd_data,
   input  wire logic        cmd_ready,
   // space and identity
   input  wire logic [7:0]  host_buf_free,
   input  wire logic [6:0]  unit_id,
   // status
   output      logic        selected,
   output      logic        tx_paused,
   output      logic        overrun
);
   import flow_ctrl_pkg::*;

   flow_state_t st;
   flow_state_t next_st;
   logic        load;
   logic        push;
   logic        buf_ready;
   logic        attn_hit;
   logic        is_digit;
   logic [6:0]  unit_num;

   // ****************************************
   // character buffer
   // ****************************************
   serial_char_buffer #(
      .WIDTH (8),
      .DEPTH (DEPTH)
   ) u_buf (
      .core_clk  (core_clk),
      .rst       (rst),
      .in_valid  (push),
      .in_data   (rx_data),
      .in_ready  (buf_ready),
      .out_valid (cmd_valid),
      .out_data  (cmd_data),
      .out_ready (cmd_ready),
      .level     ()
   );

   // ****************************************
   // next state
   // ****************************************
   assign load      = !st.tx_valid || tx_ready;
   assign app_ready = load && !st.pend_xoff && !st.pend_xon && !st.paused;
   assign is_digit  = (rx_data >= `CHAR_DIGIT_LO) && (rx_data <= `CHAR_DIGIT_HI);
   assign unit_num  = 7'(st.tens) * `TENS_WEIGHT + 7'(rx_data[3:0]);

   always_comb begin
      next_st         = st;
      next_st.overrun = 1'b0;
      push            = 1'b0;
      attn_hit        = 1'b0;
      if (st.tx_valid && tx_ready) begin
         next_st.tx_valid = 1'b0;
      end
      // flow characters jump ahead of data and are sent even while paused
      if (load) begin
         if (st.pend_xoff) begin
            next_st.tx_valid  = 1'b1;
            next_st.tx_data   = `CHAR_XOFF;
            next_st.pend_xoff = 1'b0;
         end else if (st.pend_xon) begin
            next_st.tx_valid = 1'b1;
            next_st.tx_data  = `CHAR_XON;
            next_st.pend_xon = 1'b0;
         end else if (app_valid && !st.paused) begin
            next_st.tx_valid = 1'b1;
            next_st.tx_data  = app_data;
         end
      end
      if (rx_valid) begin
         if (rx_data == `CHAR_XON) begin
            next_st.paused = 1'b0;
         end else if (rx_data == `CHAR_XOFF) begin
            next_st.paused = 1'b1;
         end else begin
            // host cannot stop at once: only a few late characters are kept
            push = !st.xoff_sent || (st.late_cnt < `LATE_CHARS);
            next_st.overrun = !push || !buf_ready;
            if (st.xoff_sent && push && buf_ready) begin
               next_st.late_cnt = st.late_cnt + 1'b1;
            end
            if (rx_data == `CHAR_CR && host_buf_free < `XOFF_FREE_MIN && !st.xoff_sent) begin
               next_st.pend_xoff = 1'b1;
               next_st.xoff_sent = 1'b1;
               next_st.late_cnt  = 2'h0;
            end
            case (st.attn)
               ATTN_IDLE: begin
                  if (rx_data == `CHAR_ATTN) begin
                     next_st.attn = ATTN_LEAD;
                  end
               end
               ATTN_LEAD: begin
                  next_st.tens = rx_data[3:0];
                  next_st.attn = is_digit ? ATTN_TENS : ATTN_IDLE;
               end
               ATTN_TENS: begin
                  next_st.attn = ATTN_IDLE;
                  if (is_digit) begin
                     attn_hit = (unit_num == unit_id) || (unit_num == `BROADCAST_UNIT);
                     next_st.selected = attn_hit;
                  end
               end
               default: begin
                  next_st.attn = ATTN_IDLE;
               end
            endcase
         end
      end
      if (st.xoff_sent && host_buf_free >= `XON_FREE_LEVEL) begin
         next_st.pend_xon  = 1'b1;
         next_st.xoff_sent = 1'b0;
         next_st.late_cnt  = 2'h0;
      end
      if (attn_hit && host_buf_free >= `XOFF_FREE_MIN) begin
         next_st.pend_xon = 1'b1;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign tx_valid  = st.tx_valid;
   assign tx_data   = st.tx_data;
   assign selected  = st.selected;
   assign tx_paused = st.paused;
   assign overrun   = st.overrun;

   // ****************************************
   // checks
   // ****************************************
   a_xoff_on_cr: assert property (@(posedge core_clk) disable iff (rst)
      rx_valid && rx_data == `CHAR_CR && host_buf_free < `XOFF_FREE_MIN && !st.xoff_sent
      |=> st.xoff_sent && (st.pend_xoff || (st.tx_valid && st.tx_data == `CHAR_XOFF)))
      else $error("no stop character after CR with low space");

   a_xon_at_space: assert property (@(posedge core_clk) disable iff (rst)
      st.xoff_sent && host_buf_free >= `XON_FREE_LEVEL
      |=> !st.xoff_sent && (st.pend_xon || (st.tx_valid && st.tx_data == `CHAR_XON)))
      else $error("no resume character once space recovered");

   a_attn_reply: assert property (@(posedge core_clk) disable iff (rst)
      attn_hit && host_buf_free >= `XOFF_FREE_MIN |=> st.pend_xon)
      else $error("attention not answered with resume");

   a_late_limit: assert property (@(posedge core_clk) disable iff (rst)
      st.xoff_sent && st.late_cnt == `LATE_CHARS && rx_valid && rx_data != `CHAR_XON && rx_data != `CHAR_XOFF
      |-> !push ##1 overrun)
      else $error("more than three characters kept after stop");

   // a held character reloaded back to back would never show a rising valid
   a_hold_off: assert property (@(posedge core_clk) disable iff (rst)
      st.paused && !st.pend_xon && !st.pend_xoff && load |=> !st.tx_valid)
      else $error("data sent while host holds us off");

   a_resume_rx: assert property (@(posedge core_clk) disable iff (rst)
      rx_valid && rx_data == `CHAR_XON |=> !st.paused ##0 !$past(push))
      else $error("host resume not honoured");

   a_broadcast: assert property (@(posedge core_clk) disable iff (rst)
      rx_valid && st.attn == ATTN_TENS && st.tens == 4'h0 && rx_data == `CHAR_DIGIT_LO
      |-> attn_hit ##1 st.selected)
      else $error("broadcast unit not accepted");

   a_xon_code: assert property (@(posedge core_clk) disable iff (rst)
      load && st.pend_xon && !st.pend_xoff |=> st.tx_valid && st.tx_data == 8'h11)
      else $error("resume character has wrong code");

   a_stop_first: assert property (@(posedge core_clk) disable iff (rst)
      load && st.pend_xoff |=> st.tx_valid && st.tx_data == `CHAR_XOFF)
      else $error("stop character not sent first");

   a_full_drop: assert property (@(posedge core_clk) disable iff (rst)
      rx_valid && rx_data != `CHAR_XON && rx_data != `CHAR_XOFF && !buf_ready |=> overrun)
      else $error("character lost on full buffer without overrun");

endmodule : host_flow_ctrl

// >>> hdl/serial_char_buffer.sv
/*
   Flip-flop character FIFO holding received host characters.
   Assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/1ps

module serial_char_buffer #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 40
) (
   // clock and reset
   input  wire logic                     core_clk,
   input  wire logic                     rst,
   // fill side
   input  wire logic                     in_valid,
   input  wire logic [WIDTH-1:0]         in_data,
   output      logic                     in_ready,
   // drain side
   output      logic                     out_valid,
   output      logic [WIDTH-1:0]         out_data,
   input  wire logic                     out_ready,
   // fill level
   output      logic [$clog2(DEPTH+1)-1:0] level
);

   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH+1);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wr;
      logic [AW-1:0]               rd;
      logic [CW-1:0]               cnt;
   } fifo_state_t;

   fifo_state_t st;
   fifo_state_t next_st;
   logic        push;
   logic        pop;

   assign in_ready  = (st.cnt != CW'(DEPTH));
   assign out_valid = (st.cnt != '0);
   assign out_data  = st.mem[st.rd];
   assign level     = st.cnt;
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb begin
      next_st = st;
      for (int i = 0; i < DEPTH; i++) begin
         if (push && st.wr == AW'(i)) begin
            next_st.mem[i] = in_data;
         end
      end
      if (push) begin
         next_st.wr = (st.wr == AW'(DEPTH-1)) ? '0 : st.wr + 1'b1;
      end
      if (pop) begin
         next_st.rd = (st.rd == AW'(DEPTH-1)) ? '0 : st.rd + 1'b1;
      end
      if (push && !pop) begin
         next_st.cnt = st.cnt + 1'b1;
      end else if (pop && !push) begin
         next_st.cnt = st.cnt - 1'b1;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   a_count_bound: assert property (@(posedge core_clk) disable iff (rst)
      st.cnt <= CW'(DEPTH))
      else $error("buffer count exceeds depth");

endmodule : serial_char_buffer

// >>> verification/host_flow_ctrl_tb.sv
/*
   Self-checking bench for the host flow-control block.
   Assumes host_term_model as the far side and a small buffer depth.
*/
`timescale 1ns/1ps
`include "flow_ctrl_regs.svh"

module host_flow_ctrl_tb;
   localparam int DEPTH = 8;
   logic       core_clk = 1'b0;
   logic       rst, rx_valid, tx_valid, tx_ready, app_valid, app_ready;
   logic       cmd_valid, cmd_ready, selected, tx_paused, overrun;
   logic [7:0] rx_data, tx_data, app_data, cmd_data, host_buf_free;
   logic [6:0] unit_id;
   int         errors = 0, n_compared = 0, mark = 0, n_pop = 0, n_ovr = 0;
   logic [7:0] last_cmd = 8'h00;

   host_flow_ctrl #(.DEPTH(DEPTH)) u_host_flow_ctrl (.core_clk(core_clk), .rst(rst), .rx_valid(rx_valid),
      .rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
      .app_valid(app_valid), .app_data(app_data), .app_ready(app_ready), .cmd_valid(cmd_valid),
      .cmd_data(cmd_data), .cmd_ready(cmd_ready), .host_buf_free(host_buf_free), .unit_id(unit_id),
      .selected(selected), .tx_paused(tx_paused), .overrun(overrun));
   host_term_model u_host_term_model (.core_clk(core_clk), .tx_valid(tx_valid), .tx_data(tx_data),
      .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data));

   // clock starts low by its initializer, so no false falling edge at time 0
   initial begin
      forever #20 core_clk = ~core_clk;
   end

   always @(posedge core_clk) begin
      if (cmd_valid === 1'b1 && cmd_ready === 1'b1) begin
         n_pop    <= n_pop + 1;
         last_cmd <= cmd_data;
      end
      if (overrun === 1'b1) n_ovr <= n_ovr + 1;
   end

   // ****************************************
   // checking helpers
   // ****************************************
   task end_of_test;
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : end_of_test

   task check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask : check

   task expect_tx(input logic [7:0] exp, input string msg);
      for (int i = 0; i < 30 && u_host_term_model.n_tx == mark; i++) @(negedge core_clk);
      if (u_host_term_model.n_tx == mark) begin
         errors++;
         $display("wrong value at %0t: %s never sent", $time, msg);
         end_of_test;
      end
      check(u_host_term_model.last_tx, exp, msg);
      mark = u_host_term_model.n_tx;
   endtask : expect_tx

   task expect_quiet(input int n, input string msg);
      repeat (n) @(negedge core_clk);
      check(u_host_term_model.n_tx, mark, msg);
   endtask : expect_quiet

   // ****************************************
   // scenarios
   // ****************************************
   task t_xoff;
      host_buf_free = 8'h52;
      u_host_term_model.send_char(`CHAR_CR);
      expect_quiet(8, "no stop at 82 free");
      host_buf_free = 8'h51;
      u_host_term_model.send_char(`CHAR_CR);
      expect_tx(`CHAR_XOFF, "stop char");
      for (int i = 0; i < 4; i++) u_host_term_model.send_char(8'h41 + 8'(i));
      @(negedge core_clk);
      check(n_ovr, 1, "late chars dropped");
      check(cmd_data, `CHAR_CR, "oldest stored char");
      cmd_ready = 1'b1;
      repeat (20) @(negedge core_clk);
      check(n_pop, 5, "stored chars");
      check(last_cmd, 8'h43, "third late char kept");
   endtask : t_xoff

   task t_xon;
      host_buf_free = 8'h63;
      expect_quiet(8, "no resume at 99 free");
      host_buf_free = 8'h64;
      expect_tx(`CHAR_XON, "resume char");
      host_buf_free = 8'h78;
   endtask : t_xon

   task t_pause;
      u_host_term_model.slow = 1'b1;
      u_host_term_model.send_char(`CHAR_XOFF);
      check(tx_paused, 1, "paused by host");
      app_valid = 1'b1;
      app_data  = 8'h5A;
      expect_quiet(10, "held while paused");
      check(app_ready, 0, "app refused");
      u_host_term_model.send_char(`CHAR_XON);
      for (int i = 0; i < 20 && app_ready !== 1'b1; i++) @(negedge core_clk);
      if (app_ready !== 1'b1) begin
         errors++;
         $display("wrong value at %0t: app data never taken after resume", $time);
         end_of_test;
      end
      @(negedge core_clk);
      app_valid = 1'b0;
      expect_tx(8'h5A, "data after resume");
      u_host_term_model.slow = 1'b0;
   endtask : t_pause

   task t_attn;
      int ids[5]  = '{5, 5, 5, 99, 5};
      int addr[5] = '{5, 7, 0, 99, 5};
      int room[5] = '{120, 120, 120, 120, 81};
      for (int i = 0; i < 5; i++) begin
         unit_id       = 7'(ids[i]);
         host_buf_free = 8'(room[i]);
         u_host_term_model.send_attn(addr[i]);
         @(negedge core_clk);
         check(selected, addr[i] != 7, "selection");
         if (addr[i] != 7 && room[i] >= 82) expect_tx(`CHAR_XON, "attention reply");
         else expect_quiet(8, "no reply to other unit or without space");
      end
      host_buf_free = 8'h78;
   endtask : t_attn

   // buffer full without any stop outstanding: the extra character is dropped
   task t_full;
      int pops;
      int drops;
      pops      = n_pop;
      drops     = n_ovr;
      cmd_ready = 1'b0;
      for (int i = 0; i <= DEPTH; i++) u_host_term_model.send_char(8'h61);
      @(negedge core_clk);
      check(n_ovr - drops, 1, "char dropped when buffer full");
      cmd_ready = 1'b1;
      repeat (2 * DEPTH) @(negedge core_clk);
      check(n_pop - pops, DEPTH, "full buffer drained");
   endtask : t_full

   initial begin
      rst           = 1'b1;
      app_valid     = 1'b0;
      app_data      = 8'h00;
      cmd_ready     = 1'b0;
      host_buf_free = 8'h78;
      unit_id       = 7'h05;
      repeat (6) @(negedge core_clk);
      rst = 1'b0;
      check({tx_valid, tx_paused, selected, overrun, cmd_valid, app_ready}, 6'h01, "after reset");
      t_xoff;
      t_xon;
      t_pause;
      t_attn;
      t_full;
      end_of_test;
   end
endmodule : host_flow_ctrl_tb

// >>> verification/host_term_model.sv
/*
   Host terminal model: sends host characters and takes device characters.
   Assumes one clock; drives its lines at the falling edge.
*/
`timescale 1ns/1ps
`include "flow_ctrl_regs.svh"

module host_term_model (
   // clock
   input  wire logic       core_clk,
   // device to host
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_data,
   output      logic       tx_ready,
   // host to device
   output      logic       rx_valid,
   output      logic [7:0] rx_data
);
   logic       slow    = 1'b0;
   int         n_tx    = 0;
   logic [7:0] last_tx = 8'h00;

   initial begin
      tx_ready = 1'b1;
      rx_valid = 1'b0;
      rx_data  = 8'h00;
   end

   // slow mode stalls every other cycle
   always @(negedge core_clk) begin
      tx_ready <= slow ? ~tx_ready : 1'b1;
   end

   always @(posedge core_clk) begin
      if (tx_valid && tx_ready) begin
         n_tx    <= n_tx + 1;
         last_tx <= tx_data;
      end
   end

   // one-cycle strobe; idle line shows the inverse so stale data is not reused
   task send_char(input logic [7:0] c);
      @(negedge core_clk);
      rx_valid = 1'b1;
      rx_data  = c;
      @(negedge core_clk);
      rx_valid = 1'b0;
      rx_data  = ~c;
   endtask : send_char

   // lead character, then two decimal digits; 0 addresses every unit
   task send_attn(input int unit);
      send_char(`CHAR_ATTN);
      send_char(`CHAR_DIGIT_LO + 8'(unit / 10));
      send_char(`CHAR_DIGIT_LO + 8'(unit % 10));
   endtask : send_attn
endmodule : host_term_model
